// [rtl/srh_ctrl.sv]
// host controller that sequences reads and writes on a static memory
`timescale 1ns/1ps
`default_nettype none
module srh_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	output logic req_ready,
	input wire srh_pkg::srh_req_t req,
	output logic rsp_valid,
	output logic [srh_pkg::DATA_W-1:0] rsp_rdata,
	output srh_pkg::srh_pins_t pins,
	input wire logic [srh_pkg::DATA_W-1:0] dq_in,
	output logic [srh_pkg::DATA_W-1:0] dq_out,
	output logic [srh_pkg::DATA_W-1:0] dq_oe_n
);
	import srh_pkg::*;

	srh_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;
	logic drive;
	logic take;
	logic pin_sel_n;
	logic pin_sel;
	logic pin_rd_en_n;
	logic pin_wr_n;
	logic [ADDR_W-1:0] pin_addr;

	// counter at its last step
	function automatic logic count_done(input logic [CNT_W-1:0] c);
		return c == CNT_ZERO;
	endfunction

	// last cycle of a read: selects drop and the byte is taken
	function automatic logic read_last(input srh_state_t s, input logic [CNT_W-1:0] c);
		return (s == ST_READ) && count_done(c);
	endfunction

	// last cycle of the write strobe
	function automatic logic write_last(input srh_state_t s, input logic [CNT_W-1:0] c);
		return (s == ST_WRITE) && count_done(c);
	endfunction

	assign req_ready = (state == ST_IDLE);
	assign take = req_valid && req_ready;
	assign pins = '{
		sel_n: pin_sel_n,
		sel: pin_sel,
		rd_en_n: pin_rd_en_n,
		wr_n: pin_wr_n,
		addr: pin_addr
	};

	// two-stage capture of the pad inputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else begin
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	// access sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
			cnt <= CNT_ZERO;
		end else begin
			case (state)
				ST_IDLE: begin
					if (req_valid) begin
						state <= req.write ? ST_WRITE : ST_READ;
						// extra two cycles on read cover the input synchroniser
						cnt <= req.write ? CNT_W'(WRITE_CYC - 1) : CNT_W'(READ_CYC + 1);
					end
				end
				ST_READ: begin
					if (cnt == CNT_ZERO) begin
						state <= ST_TURN;
						cnt <= CNT_W'(TURN_CYC - 1);
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_WRITE: begin
					if (cnt == CNT_ZERO) begin
						state <= ST_WHOLD;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_WHOLD: begin
					state <= ST_IDLE;
				end
				ST_TURN: begin
					if (cnt == CNT_ZERO) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// address and write data latched at request, held through the access
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_addr <= 17'h0_0000;
			dq_out <= 8'h00;
		end else if (take) begin
			pin_addr <= req.addr;
			dq_out <= req.wdata;
		end
	end

	// both selects move together; a write keeps them one cycle past the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_sel_n <= 1'b1;
			pin_sel <= 1'b0;
		end else if (take) begin
			pin_sel_n <= 1'b0;
			pin_sel <= 1'b1;
		end else if ((state == ST_WHOLD) || read_last(state, cnt)) begin
			pin_sel_n <= 1'b1;
			pin_sel <= 1'b0;
		end
	end

	// read drive enable stays high through writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_rd_en_n <= 1'b1;
		end else if (take) begin
			pin_rd_en_n <= req.write;
		end else if (read_last(state, cnt)) begin
			pin_rd_en_n <= 1'b1;
		end
	end

	// write strobe; its rising edge ends the write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_wr_n <= 1'b1;
		end else if (take) begin
			pin_wr_n <= ~req.write;
		end else if (write_last(state, cnt)) begin
			pin_wr_n <= 1'b1;
		end
	end

	// data drive, released together with the selects
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			drive <= 1'b0;
		end else if (take) begin
			drive <= req.write;
		end else if (state == ST_WHOLD) begin
			drive <= 1'b0;
		end
	end

	assign dq_oe_n = {DATA_W{~drive}};

	// read answer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= read_last(state, cnt);
			if (read_last(state, cnt)) begin
				rsp_rdata <= dq_sync;
			end
		end
	end
endmodule // srh_ctrl
`default_nettype wire

// [shared/srh_pkg.sv]
// constants and types for the static memory host controller
// Notes on behaviour
// - A write happens while the low select and write strobe are low and the high select is high.
// - A read happens while low select and read enable are low and strobe and high select are high.
// - A write starts once all three write terms hold and ends when select or strobe rises.
// - Write data is held stable around the rising edge that ends the write.
// - A strobe-ended write with read enable low lasts at least float time plus data set-up.
// - The controller never drives the data lines while the memory may drive them.
// - For a select-controlled read the address is valid no later than the selects go active.
// - The write strobe stays high through every read.
package srh_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 40;
	// grade figures, 70 ns grade as the safe default
	localparam int READ_CYCLE_TIME_NS = 70;
	localparam int WRITE_PULSE_NS = 55;
	localparam int WRITE_DATA_SETUP_NS = 30;
	localparam int STROBE_LOW_TO_FLOAT_NS = 25;
	localparam int ADDR_SETUP_NS = 0;
	localparam int TURN_NS = 25;
	// least times round up
	localparam int READ_CYC = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_MIN_NS = (WRITE_PULSE_NS > STROBE_LOW_TO_FLOAT_NS + WRITE_DATA_SETUP_NS) ?
		WRITE_PULSE_NS : STROBE_LOW_TO_FLOAT_NS + WRITE_DATA_SETUP_NS;
	localparam int WRITE_CYC = (WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC0 = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC = (TURN_CYC0 < 1) ? 1 : TURN_CYC0;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} srh_req_t;

	typedef struct packed {
		logic sel_n;
		logic sel;
		logic rd_en_n;
		logic wr_n;
		logic [ADDR_W-1:0] addr;
	} srh_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_WHOLD,
		ST_TURN
	} srh_state_t;
endpackage : srh_pkg

// [tb/srh_assertions.sv]
// host controller pin assertions
`timescale 1ns/1ps
`default_nettype none
module srh_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire srh_pkg::srh_req_t req,
	input wire logic rsp_valid,
	input wire srh_pkg::srh_pins_t pins,
	input wire logic [7:0] dq_out,
	input wire logic [7:0] dq_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_wr; req_valid && req_ready && req.write; endsequence
	sequence s_rd; req_valid && req_ready && !req.write; endsequence
	chk_rd_go: assert property (s_rd |=> !pins.sel_n && pins.sel && !pins.rd_en_n)
		else $error("no read select");
	chk_rd_ans: assert property (s_rd |-> ##[5:7] rsp_valid)
		else $error("no read answer");
	chk_wr_go: assert property (s_wr |=> !pins.wr_n && pins.sel && dq_out == $past(req.wdata))
		else $error("bad write start");
	chk_wr_len: assert property ($fell(pins.wr_n) |=> !pins.wr_n ##1 pins.wr_n)
		else $error("bad strobe width");
	chk_wr_hold: assert property ($rose(pins.wr_n) |-> !pins.sel_n && $stable(dq_out))
		else $error("write data moved");
	chk_rd_strobe: assert property (!pins.rd_en_n |-> pins.wr_n)
		else $error("strobe low in read");
	chk_no_clash: assert property (!pins.rd_en_n || $past(!pins.rd_en_n) |-> &dq_oe_n)
		else $error("bus contention");
	chk_addr_set: assert property (req_valid && req_ready |=> pins.addr == $past(req.addr))
		else $error("address not presented");
	chk_addr_hold: assert property (!pins.sel_n && $past(!pins.sel_n) |-> $stable(pins.addr))
		else $error("address moved");
endmodule // srh_assertions
bind srh_ctrl srh_assertions chk (
	.clk(clk),
	.reset(reset),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.req(req),
	.rsp_valid(rsp_valid),
	.pins(pins),
	.dq_out(dq_out),
	.dq_oe_n(dq_oe_n)
);
`default_nettype wire

// [tb/srh_mem_model.sv]
// behavioural static memory at the host pins
`timescale 1ns/1ps
`default_nettype none
module srh_mem (
	input wire srh_pkg::srh_pins_t pins,
	input wire logic [7:0] dq_out,
	input wire logic [7:0] dq_oe_n,
	output logic [7:0] dq
);
	logic [7:0] mem [2**17];
	logic [7:0] last = 8'h00;
	logic rd_ok = 1'b0;
	realtime t_wr = 0.0;
	realtime t_dat = 0.0;
	wire logic on = !pins.sel_n && pins.sel;
	wire logic rd_on = on && !pins.rd_en_n && pins.wr_n;
	wire logic wr_on = on && !pins.wr_n;
	// a write lands at its ending edge only if strobe and data were held long enough
	always @(posedge wr_on) t_wr = $realtime;
	always @(dq_out) t_dat = $realtime;
	always @(negedge wr_on) begin
		if ($realtime - t_wr >= srh_pkg::WRITE_PULSE_NS &&
			$realtime - t_wr >= srh_pkg::STROBE_LOW_TO_FLOAT_NS + srh_pkg::WRITE_DATA_SETUP_NS &&
			$realtime - t_dat >= srh_pkg::WRITE_DATA_SETUP_NS)
			mem[pins.addr] = dq_out;
	end
	// read data stands only once the access time has passed
	always @(rd_on or pins.addr) begin
		rd_ok = 1'b0;
		if (rd_on)
			rd_ok <= #(srh_pkg::READ_CYCLE_TIME_NS) 1'b1;
	end
	always @(negedge rd_on) last = mem[pins.addr];
	always_comb dq = !dq_oe_n[0] ? dq_out : (rd_on && rd_ok) ? mem[pins.addr] : ~last;
endmodule // srh_mem
`default_nettype wire

// [tb/tb_top.sv]
// bench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import srh_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	srh_req_t req = '0;
	logic req_ready, rsp_valid;
	logic [7:0] rsp_rdata, dq_in, dq_out, dq_oe_n;
	srh_pins_t pins;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	srh_ctrl uut (
		.clk(clk),
		.reset(reset),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req(req),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.pins(pins),
		.dq_in(dq_in),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n)
	);
	srh_mem mem (
		.pins(pins),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n),
		.dq(dq_in)
	);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t: %h not %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic op(input logic w, input logic [16:0] a, input logic [7:0] d);
		while (req_ready !== 1'b1)
			@(posedge clk) #1;
		req_valid = 1'b1;
		req = '{w, a, d};
		@(posedge clk) #1 req_valid = 1'b0;
	endtask
	task automatic rd(input logic [16:0] a, input logic [7:0] e);
		int n = 0;
		op(1'b0, a, 8'h00);
		while (rsp_valid !== 1'b1 && n < 8) begin
			@(posedge clk) #1;
			n++;
		end
		chk(rsp_valid, 1'b1);
		chk(n, READ_CYC + 2);
		chk(rsp_rdata, e);
		@(posedge clk) #1;
		chk(rsp_valid, 1'b0);
	endtask
	task automatic t_midreset();
		op(1'b1, 17'h0_0042, 8'h77);
		reset = 1'b1;
		#1 chk({pins, dq_oe_n, req_ready, rsp_valid}, {4'hB, 17'h0_0000, 8'hFF, 2'b10});
		@(posedge clk) #1 reset = 1'b0;
		rd(17'h1_FFFF, 8'h5A);
	endtask
	task automatic t_reset();
		chk({pins, dq_oe_n, req_ready, rsp_valid}, {4'hB, 17'h0_0000, 8'hFF, 2'b10});
	endtask
	task automatic t_edges();
		op(1'b1, 17'h0_0000, 8'hA5);
		op(1'b1, 17'h1_FFFF, 8'h5A);
		rd(17'h0_0000, 8'hA5);
		rd(17'h1_FFFF, 8'h5A);
	endtask
	task automatic t_keep();
		op(1'b1, 17'h0_1234, 8'h3C);
		op(1'b1, 17'h0_1234, 8'hC3);
		rd(17'h0_1234, 8'hC3);
		rd(17'h0_1234, 8'hC3);
		rd(17'h0_0000, 8'hA5);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1 t_reset();
		reset = 1'b0;
		t_edges();
		t_keep();
		t_midreset();
		give_verdict();
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			miscompares++;
			give_verdict();
		end
	end
endmodule // tb_top
`default_nettype wire
